//--- rtl/pwd_pkg.sv
// Constants, register map and event carrier for the three-generator PWM unit
package pwd_pkg;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  localparam int NGEN = 3;
  localparam int NOUT = 6;
  localparam int CW   = 16;
  localparam int DBW  = 12;
  localparam int NEV  = 6;
  localparam int AW   = 12;
  // ----------------------------------------
  // Global register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_CTL    = 12'h000;
  localparam logic [AW-1:0] OFS_SYNC   = 12'h004;
  localparam logic [AW-1:0] OFS_ENABLE = 12'h008;
  localparam logic [AW-1:0] OFS_INVERT = 12'h00c;
  localparam logic [AW-1:0] OFS_FAULT  = 12'h010;
  localparam logic [AW-1:0] OFS_STATUS = 12'h020;
  // Generator g sits at 0x040 * (g + 1), 64 bytes each
  localparam int GSEL_LSB = 6;
  localparam int GSEL_MSB = 7;
  // ----------------------------------------
  // Offsets inside a generator window
  // ----------------------------------------
  localparam logic [5:0] GO_CTL    = 6'h00;
  localparam logic [5:0] GO_INTEN  = 6'h04;
  localparam logic [5:0] GO_LOAD   = 6'h10;
  localparam logic [5:0] GO_COUNT  = 6'h14;
  localparam logic [5:0] GO_CMPA   = 6'h18;
  localparam logic [5:0] GO_CMPB   = 6'h1c;
  localparam logic [5:0] GO_GENA   = 6'h20;
  localparam logic [5:0] GO_GENB   = 6'h24;
  localparam logic [5:0] GO_DBCTL  = 6'h28;
  localparam logic [5:0] GO_DBRISE = 6'h2c;
  localparam logic [5:0] GO_DBFALL = 6'h30;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_EN       = 0;
  localparam int CTL_UPDN     = 1;
  localparam int CTL_LDSYNC   = 2;
  localparam int CTL_CMPSYNC  = 3;
  localparam int CTL_W        = 4;
  localparam int INT_SEL_LSB  = 0;
  localparam int TRIG_SEL_LSB = 8;
  localparam int STAT_FAULT   = 0;
  localparam int STAT_DIR_LSB = 1;
  localparam int EV_ZERO      = 0;
  localparam int EV_LOAD      = 1;
  localparam int EV_AUP       = 2;
  localparam int EV_ADN       = 3;
  localparam int EV_BUP       = 4;
  localparam int EV_BDN       = 5;
  // ----------------------------------------
  // Output actions
  // ----------------------------------------
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_INV  = 2'h1;
  localparam logic [1:0] ACT_LOW  = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;

  // Bit order matches EV_* positions
  typedef struct packed {
    logic bdn;
    logic bup;
    logic adn;
    logic aup;
    logic ld;
    logic zero;
  } pwd_evt_t;
endpackage

//--- rtl/pwd_top.sv
// Three-generator PWM unit with dead-band and output control
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
module pwd_top
  import pwd_pkg::*;
(
  input  wire logic          REF_CLK,
  input  wire logic          RST,
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR_STB,
  input  wire logic          RD_STB,
  output logic      [31:0]   RDATA,
  input  wire logic          FAULT,
  output logic               OUT_PIN_0,
  output logic               OUT_PIN_1,
  output logic               OUT_PIN_2,
  output logic               OUT_PIN_3,
  output logic               OUT_PIN_4,
  output logic               OUT_PIN_5,
  output logic [NGEN-1:0]    IRQ_PULSE,
  output logic [NGEN-1:0]    ADC_TRIG
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [CTL_W-1:0] ctl_r     [NGEN];
  logic [13:0]      inten_r   [NGEN];
  logic [CW-1:0]    load_sh_r [NGEN];
  logic [CW-1:0]    cmpa_sh_r [NGEN];
  logic [CW-1:0]    cmpb_sh_r [NGEN];
  logic [CW-1:0]    load_r    [NGEN];
  logic [CW-1:0]    cmpa_r    [NGEN];
  logic [CW-1:0]    cmpb_r    [NGEN];
  logic [CW-1:0]    cnt_r     [NGEN];
  logic [11:0]      gena_r    [NGEN];
  logic [11:0]      genb_r    [NGEN];
  logic [DBW-1:0]   dbrise_r  [NGEN];
  logic [DBW-1:0]   dbfall_r  [NGEN];
  logic [DBW-1:0]   rcnt_r    [NGEN];
  logic [DBW-1:0]   fcnt_r    [NGEN];
  logic [NGEN-1:0]  dir_r;
  logic [NGEN-1:0]  db_en_r;
  logic [NGEN-1:0]  gen_a_r;
  logic [NGEN-1:0]  gen_b_r;
  logic [NGEN-1:0]  pend_r;
  logic [NOUT-1:0]  en_r;
  logic [NOUT-1:0]  inv_r;
  logic [NOUT-1:0]  fmask_r;
  logic [NOUT-1:0]  pin_r;
  logic [NGEN-1:0]  irq_r;
  logic [NGEN-1:0]  trig_r;
  logic [31:0]      rdata_r;

  pwd_evt_t         evt       [NGEN];
  logic [CW-1:0]    ld_use    [NGEN];
  logic [NGEN-1:0]  dirq;
  logic [NGEN-1:0]  copy_ld;
  logic [NGEN-1:0]  copy_cmp;
  logic [NGEN-1:0]  upd_set;
  logic [NGEN-1:0]  sync_rst;
  logic [NGEN-1:0]  gen_out_first;
  logic [NGEN-1:0]  gen_out_second;
  logic [NOUT-1:0]  raw_out;
  logic [31:0]      rd_val;
  logic             ghit;
  logic [1:0]       gsel;
  logic [5:0]       goff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic act(input logic cur, input logic [1:0] code);
    case (code)
      ACT_KEEP: act = cur;
      ACT_INV:  act = ~cur;
      ACT_LOW:  act = 1'b0;
      ACT_HIGH: act = 1'b1;
      default:  act = cur;
    endcase
  endfunction

  function automatic logic gen_step(input logic cur, input pwd_evt_t e,
                                    input logic [11:0] acts, input logic use_a,
                                    input logic use_b);
    logic v;
    v = cur;
    if (e.zero) v = act(v, acts[2*EV_ZERO +: 2]);
    if (e.ld) v = act(v, acts[2*EV_LOAD +: 2]);
    if (e.aup && use_a) v = act(v, acts[2*EV_AUP +: 2]);
    if (e.adn && use_a) v = act(v, acts[2*EV_ADN +: 2]);
    if (e.bup && use_b) v = act(v, acts[2*EV_BUP +: 2]);
    if (e.bdn && use_b) v = act(v, acts[2*EV_BDN +: 2]);
    gen_step = v;
  endfunction

  // Window g+1 of the address space belongs to generator g
  function automatic logic gen_hit(input logic [AW-1:0] a, input int g);
    gen_hit = (a[AW-1:GSEL_MSB+1] == '0) &&
              (a[GSEL_MSB:GSEL_LSB] == 2'(g + 1));
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    ghit = 1'b0;
    gsel = 2'h0;
    for (int g = 0; g < NGEN; g++) begin
      if (gen_hit(ADDR, g)) begin
        ghit = 1'b1;
        gsel = 2'(g);
      end
    end
    goff = ADDR[5:0];
  end

  // Global update and counter sync are write pulses, not stored
  assign upd_set  = (WR_STB && ADDR == OFS_CTL) ? WDATA[NGEN-1:0] : '0;
  assign sync_rst = (WR_STB && ADDR == OFS_SYNC) ? WDATA[NGEN-1:0] : '0;

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_r    <= RST_VAL[NOUT-1:0];
      inv_r   <= RST_VAL[NOUT-1:0];
      fmask_r <= RST_VAL[NOUT-1:0];
    end else if (WR_STB) begin
      if (ADDR == OFS_ENABLE) en_r <= WDATA[NOUT-1:0];
      if (ADDR == OFS_INVERT) inv_r <= WDATA[NOUT-1:0];
      if (ADDR == OFS_FAULT) fmask_r <= WDATA[NOUT-1:0];
    end
  end

  // ----------------------------------------
  // Generator configuration and shadows
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int g = 0; g < NGEN; g++) begin
      if (RST) begin
        ctl_r[g]     <= '0;
        inten_r[g]   <= '0;
        load_sh_r[g] <= '0;
        cmpa_sh_r[g] <= '0;
        cmpb_sh_r[g] <= '0;
        gena_r[g]    <= '0;
        genb_r[g]    <= '0;
        db_en_r[g]   <= 1'b0;
        dbrise_r[g]  <= '0;
        dbfall_r[g]  <= '0;
      end else if (WR_STB && ghit && gsel == 2'(g)) begin
        case (goff)
          GO_CTL:    ctl_r[g] <= WDATA[CTL_W-1:0];
          GO_INTEN:  inten_r[g] <= WDATA[13:0];
          GO_LOAD:   load_sh_r[g] <= WDATA[CW-1:0];
          GO_CMPA:   cmpa_sh_r[g] <= WDATA[CW-1:0];
          GO_CMPB:   cmpb_sh_r[g] <= WDATA[CW-1:0];
          GO_GENA:   gena_r[g] <= WDATA[11:0];
          GO_GENB:   genb_r[g] <= WDATA[11:0];
          GO_DBCTL:  db_en_r[g] <= WDATA[0];
          GO_DBRISE: dbrise_r[g] <= WDATA[DBW-1:0];
          GO_DBFALL: dbfall_r[g] <= WDATA[DBW-1:0];
          default:   ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Update timing
  // ----------------------------------------
  // Copy only at zero, or while the counter is disabled, so a period never runs half old, half new
  always_comb begin
    for (int g = 0; g < NGEN; g++) begin
      copy_ld[g]  = (evt[g].zero || !ctl_r[g][CTL_EN]) &&
                    (!ctl_r[g][CTL_LDSYNC] || pend_r[g]);
      copy_cmp[g] = (evt[g].zero || !ctl_r[g][CTL_EN]) &&
                    (!ctl_r[g][CTL_CMPSYNC] || pend_r[g]);
      ld_use[g]   = copy_ld[g] ? load_sh_r[g] : load_r[g];
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int g = 0; g < NGEN; g++) begin
      if (RST) begin
        load_r[g] <= '0;
        cmpa_r[g] <= '0;
        cmpb_r[g] <= '0;
        pend_r[g] <= 1'b0;
      end else begin
        if (copy_ld[g]) load_r[g] <= load_sh_r[g];
        if (copy_cmp[g]) begin
          cmpa_r[g] <= cmpa_sh_r[g];
          cmpb_r[g] <= cmpb_sh_r[g];
        end
        // Arming write wins over the consuming zero
        pend_r[g] <= upd_set[g] ||
                     (pend_r[g] && !(evt[g].zero || !ctl_r[g][CTL_EN]));
      end
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int g = 0; g < NGEN; g++) begin
      if (RST) begin
        cnt_r[g] <= '0;
        dir_r[g] <= 1'b0;
      end else if (sync_rst[g]) begin
        cnt_r[g] <= '0;
        dir_r[g] <= 1'b0;
      end else if (ctl_r[g][CTL_EN]) begin
        if (!ctl_r[g][CTL_UPDN]) begin
          dir_r[g] <= 1'b0;
          cnt_r[g] <= (cnt_r[g] == '0) ? ld_use[g] : cnt_r[g] - 16'h0001;
        end else if (dir_r[g]) begin
          if (cnt_r[g] >= load_r[g]) begin
            dir_r[g] <= 1'b0;
            cnt_r[g] <= (cnt_r[g] == '0) ? '0 : cnt_r[g] - 16'h0001;
          end else begin
            cnt_r[g] <= cnt_r[g] + 16'h0001;
          end
        end else if (cnt_r[g] == '0) begin
          dir_r[g] <= 1'b1;
          cnt_r[g] <= (ld_use[g] == '0) ? '0 : 16'h0001;
        end else begin
          cnt_r[g] <= cnt_r[g] - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Counter and comparator events
  // ----------------------------------------
  always_comb begin
    logic ma;
    logic mb;
    ma = 1'b0;
    mb = 1'b0;
    for (int g = 0; g < NGEN; g++) begin
      dirq[g]     = ctl_r[g][CTL_UPDN] && dir_r[g];
      evt[g].zero = ctl_r[g][CTL_EN] && cnt_r[g] == '0;
      evt[g].ld   = ctl_r[g][CTL_EN] && cnt_r[g] == load_r[g];
      ma = ctl_r[g][CTL_EN] && cnt_r[g] == cmpa_r[g] && cmpa_r[g] <= load_r[g];
      mb = ctl_r[g][CTL_EN] && cnt_r[g] == cmpb_r[g] && cmpb_r[g] <= load_r[g];
      ma = ma && !(evt[g].zero || evt[g].ld);
      mb = mb && !(evt[g].zero || evt[g].ld);
      // Count-down holds direction low, so only down matches exist there
      evt[g].aup  = ma && dirq[g];
      evt[g].adn  = ma && !dirq[g];
      evt[g].bup  = mb && dirq[g];
      evt[g].bdn  = mb && !dirq[g];
    end
  end

  // ----------------------------------------
  // Signal generators
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int g = 0; g < NGEN; g++) begin
      if (RST) begin
        gen_a_r[g] <= 1'b0;
        gen_b_r[g] <= 1'b0;
      end else begin
        gen_a_r[g] <= gen_step(gen_a_r[g], evt[g], gena_r[g], 1'b1,
                               !(evt[g].aup || evt[g].adn));
        gen_b_r[g] <= gen_step(gen_b_r[g], evt[g], genb_r[g],
                               !(evt[g].bup || evt[g].bdn), 1'b1);
      end
    end
  end

  // ----------------------------------------
  // Dead-band
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int g = 0; g < NGEN; g++) begin
      if (RST) begin
        rcnt_r[g] <= '0;
        fcnt_r[g] <= '0;
      end else begin
        if (!gen_a_r[g]) rcnt_r[g] <= '0;
        else if (rcnt_r[g] != dbrise_r[g]) rcnt_r[g] <= rcnt_r[g] + 12'h001;
        if (gen_a_r[g]) fcnt_r[g] <= '0;
        else if (fcnt_r[g] != dbfall_r[g]) fcnt_r[g] <= fcnt_r[g] + 12'h001;
      end
    end
  end

  always_comb begin
    for (int g = 0; g < NGEN; g++) begin
      gen_out_first[g]  = db_en_r[g] ? (gen_a_r[g] && rcnt_r[g] == dbrise_r[g])
                                     : gen_a_r[g];
      gen_out_second[g] = db_en_r[g] ? (!gen_a_r[g] && fcnt_r[g] == dbfall_r[g])
                                     : gen_b_r[g];
      raw_out[2*g]      = gen_out_first[g];
      raw_out[2*g+1]    = gen_out_second[g];
    end
  end

  // ----------------------------------------
  // Output control, interrupt and trigger
  // ----------------------------------------
  // Inactive level is low before inversion, so an inverted pin idles high
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_r  <= '0;
      irq_r  <= '0;
      trig_r <= '0;
    end else begin
      pin_r <= (raw_out & en_r & ~(fmask_r & {NOUT{FAULT}})) ^ inv_r;
      for (int g = 0; g < NGEN; g++) begin
        irq_r[g]  <= |(evt[g] & inten_r[g][INT_SEL_LSB +: NEV]);
        trig_r[g] <= |(evt[g] & inten_r[g][TRIG_SEL_LSB +: NEV]);
      end
    end
  end

  assign OUT_PIN_0 = pin_r[0];
  assign OUT_PIN_1 = pin_r[1];
  assign OUT_PIN_2 = pin_r[2];
  assign OUT_PIN_3 = pin_r[3];
  assign OUT_PIN_4 = pin_r[4];
  assign OUT_PIN_5 = pin_r[5];
  assign IRQ_PULSE = irq_r;
  assign ADC_TRIG  = trig_r;

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_comb begin
    rd_val = '0;
    case (ADDR)
      OFS_CTL:    rd_val[NGEN-1:0] = pend_r;
      OFS_ENABLE: rd_val[NOUT-1:0] = en_r;
      OFS_INVERT: rd_val[NOUT-1:0] = inv_r;
      OFS_FAULT:  rd_val[NOUT-1:0] = fmask_r;
      OFS_STATUS: begin
        rd_val[STAT_FAULT] = FAULT;
        rd_val[STAT_DIR_LSB +: NGEN] = dirq;
      end
      default: ;
    endcase
    if (ghit) begin
      case (goff)
        GO_CTL:    rd_val[CTL_W-1:0] = ctl_r[gsel];
        GO_INTEN:  rd_val[13:0] = inten_r[gsel];
        GO_LOAD:   rd_val[CW-1:0] = load_sh_r[gsel];
        GO_COUNT:  rd_val[CW-1:0] = cnt_r[gsel];
        GO_CMPA:   rd_val[CW-1:0] = cmpa_sh_r[gsel];
        GO_CMPB:   rd_val[CW-1:0] = cmpb_sh_r[gsel];
        GO_GENA:   rd_val[11:0] = gena_r[gsel];
        GO_GENB:   rd_val[11:0] = genb_r[gsel];
        GO_DBCTL:  rd_val[0] = db_en_r[gsel];
        GO_DBRISE: rd_val[DBW-1:0] = dbrise_r[gsel];
        GO_DBFALL: rd_val[DBW-1:0] = dbfall_r[gsel];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) rdata_r <= RST_VAL;
    else rdata_r <= RD_STB ? rd_val : RST_VAL;
  end

  assign RDATA = rdata_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_down_reload: assert property (
    (ctl_r[0][CTL_EN] && !ctl_r[0][CTL_UPDN] && cnt_r[0] == '0 && !sync_rst[0])
    |=> cnt_r[0] == $past(ld_use[0]))
    else $error("count-down did not reload at zero");

  a_load_follows: assert property (
    (evt[0].zero && !ctl_r[0][CTL_UPDN] && !sync_rst[0] && !upd_set[0])
    |=> (evt[0].ld || !ctl_r[0][CTL_EN]))
    else $error("load pulse missing after zero");

  a_updn_turn: assert property (
    (ctl_r[1][CTL_EN] && ctl_r[1][CTL_UPDN] && dir_r[1] && cnt_r[1] == load_r[1]
     && load_r[1] != '0 && !sync_rst[1])
    |=> (!dir_r[1] && cnt_r[1] == $past(load_r[1]) - 16'h0001))
    else $error("up/down did not turn at load");

  a_down_dir: assert property (
    !ctl_r[0][CTL_UPDN] |-> !dirq[0])
    else $error("direction high in count-down");

  a_cmp_range: assert property (
    (cmpa_r[0] > load_r[0]) |-> !(evt[0].aup || evt[0].adn))
    else $error("match above load value");

  a_match_mask: assert property (
    (evt[0].zero || evt[0].ld) |-> !(evt[0].aup || evt[0].adn || evt[0].bup || evt[0].bdn))
    else $error("match not masked by zero or load");

  a_hold_off: assert property (
    (!ctl_r[0][CTL_EN] && !sync_rst[0]) |=> cnt_r[0] == $past(cnt_r[0]))
    else $error("disabled counter moved");

  a_db_gap: assert property (
    db_en_r[0] |-> !(gen_out_first[0] && gen_out_second[0]))
    else $error("dead-band outputs overlap");

  a_db_pass: assert property (
    !db_en_r[0] |-> (gen_out_first[0] == gen_a_r[0] && gen_out_second[0] == gen_b_r[0]))
    else $error("bypass altered outputs");

  a_fault_pin: assert property (
    (FAULT && fmask_r[0]) |=> OUT_PIN_0 == $past(inv_r[0]))
    else $error("faulted output not inactive");

  a_trig_sel: assert property (
    (|(evt[0] & inten_r[0][TRIG_SEL_LSB +: NEV])) |=> ADC_TRIG[0])
    else $error("selected event gave no trigger");

  c_down_wrap: cover property (evt[0].zero ##1 evt[0].ld);
  c_updn_turn: cover property (dirq[1] ##1 !dirq[1] && ctl_r[1][CTL_UPDN]);
  c_db_delay:  cover property (db_en_r[0] && gen_a_r[0] && !gen_out_first[0]);
  c_fault_hit: cover property (FAULT && fmask_r[0] && en_r[0]);

endmodule

//--- testbench/pwd_gate_load.sv
// Gate driver load model: per-pin high-time counters and shoot-through detector on pins 0 and 1
`timescale 1ns/10ps
module pwd_gate_load (
  input  wire logic             clk,
  input  wire logic             clr,
  input  wire logic [5:0]       pins,
  output logic      [5:0][15:0] hi_cnt,
  output logic      [15:0]      shoot_cnt
);
  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + {15'h0000, pins[i]};
    end
    // Both switches of one leg on at once would short the supply
    shoot_cnt <= clr ? 16'h0000 : shoot_cnt + {15'h0000, pins[0] & pins[1]};
  end
endmodule

//--- testbench/pwd_top_tb.sv
// Self-checking bench for the three-generator PWM unit
`timescale 1ns/10ps
module pwd_top_tb;
  import pwd_pkg::*;
  logic                REF_CLK = 1'b0;
  logic                RST     = 1'b1;
  logic                WR_STB  = 1'b0;
  logic                RD_STB  = 1'b0;
  logic                FAULT   = 1'b0;
  logic                clr     = 1'b1;
  logic                meas    = 1'b0;
  logic                prev_irq;
  logic [AW-1:0]       ADDR    = 12'h000;
  logic [31:0]         WDATA   = 32'h0000_0000;
  logic [31:0]         RDATA;
  logic [31:0]         rd_v;
  logic [31:0]         d;
  logic [5:0]          pins;
  logic [NGEN-1:0]     IRQ_PULSE;
  logic [NGEN-1:0]     ADC_TRIG;
  logic [5:0][15:0]    hi_cnt;
  logic [15:0]         shoot_cnt;
  int fails = 0, num_checks = 0, seed = 95097;
  int n_irq, n_trg, bad, gs, L, C, R, F, k;

  always #50 REF_CLK = ~REF_CLK;

  pwd_top pwd_top_i (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .FAULT(FAULT),
    .OUT_PIN_0(pins[0]), .OUT_PIN_1(pins[1]), .OUT_PIN_2(pins[2]),
    .OUT_PIN_3(pins[3]), .OUT_PIN_4(pins[4]), .OUT_PIN_5(pins[5]),
    .IRQ_PULSE(IRQ_PULSE), .ADC_TRIG(ADC_TRIG));
  pwd_gate_load pwd_gate_load_i (.clk(REF_CLK), .clr(clr), .pins(pins),
    .hi_cnt(hi_cnt), .shoot_cnt(shoot_cnt));

  // ----------------------------------------
  // Event counting in the measuring window
  // ----------------------------------------
  always @(posedge REF_CLK) begin
    prev_irq <= IRQ_PULSE[gs];
    if (meas) begin
      if (IRQ_PULSE[gs] === 1'b1) n_irq++;
      if (ADC_TRIG[gs] === 1'b1) n_trg++;
      if (ADC_TRIG[gs] === 1'b1 && prev_irq !== 1'b1) bad++;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [AW-1:0] a, input logic [31:0] v);
    @(posedge REF_CLK); ADDR <= a; WDATA <= v; WR_STB <= 1'b1;
    @(posedge REF_CLK); WR_STB <= 1'b0;
  endtask
  task rd(input logic [AW-1:0] a);
    @(posedge REF_CLK); ADDR <= a; RD_STB <= 1'b1;
    @(posedge REF_CLK); RD_STB <= 1'b0;
    #1 rd_v = RDATA;
  endtask
  function automatic logic [31:0] av(input logic [1:0] c, input int e);
    return 32'(c) << (2 * e);
  endfunction
  function automatic logic [AW-1:0] ga(input int g, input logic [5:0] o);
    return AW'(64 * (g + 1)) | AW'(o);
  endfunction
  // Counts pins and events over exactly cyc sampling edges
  task measure(input int cyc);
    @(posedge REF_CLK); clr <= 1'b1;
    @(posedge REF_CLK); clr <= 1'b0; meas <= 1'b1;
    n_irq = 0; n_trg = 0; bad = 0;
    repeat (cyc) @(posedge REF_CLK);
    meas <= 1'b0;
    #1;
  endtask
  task wait_irq(input int g);
    int i;
    for (i = 0; i < 3000 && IRQ_PULSE[g] !== 1'b1; i++) @(posedge REF_CLK);
    if (i == 3000) begin
      fails++;
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    gs = 0;
    k = 4;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(ga(0, GO_GENA)); chk("gena_rst", rd_v, RST_VAL);
    chk("pins_rst", {26'h0, pins}, 32'h0000_0000);
    rd(12'h03c); chk("unmapped", rd_v, 32'h0000_0000);
    wr(ga(2, GO_COUNT), 32'h1234_5678); rd(ga(2, GO_COUNT));
    chk("count_ro", rd_v, 32'h0000_0000);
    for (int g = 0; g < NGEN; g++) begin
      d = $random(seed);
      wr(ga(g, GO_LOAD), d); rd(ga(g, GO_LOAD));
      chk("load_rw", rd_v, {16'h0000, d[15:0]});
    end
    for (int it = 0; it < 3; it++) begin
      L = 4 + ($unsigned($random(seed)) % 20);
      // First pass puts the match right below the load value
      C = (it == 0) ? L - 1 : 1 + ($unsigned($random(seed)) % (L - 1));
      R = $unsigned($random(seed)) % (L - C + 1);
      F = $unsigned($random(seed)) % C;
      wr(ga(0, GO_CTL), 0); wr(ga(0, GO_DBCTL), 0);
      wr(ga(0, GO_LOAD), L); wr(ga(0, GO_CMPA), C);
      wr(ga(0, GO_GENA), 32'(ACT_HIGH) | (32'(ACT_LOW) << (2 * EV_ADN)));
      wr(ga(0, GO_INTEN), 32'h0000_0201); wr(OFS_ENABLE, 32'h0000_0003);
      wr(ga(0, GO_CTL), 1);
      wait_irq(0); measure(k * (L + 1));
      chk("cd_zero", n_irq, k);
      chk("cd_load", n_trg, k);
      chk("load_after_zero", bad, 0);
      chk("pin0_high", {16'h0000, hi_cnt[0]}, k * (L - C + 1));
      chk("pin1_keep", {16'h0000, hi_cnt[1]}, 0);
      wr(ga(0, GO_DBRISE), R); wr(ga(0, GO_DBFALL), F); wr(ga(0, GO_DBCTL), 1);
      wait_irq(0); measure(k * (L + 1));
      chk("db_first", {16'h0000, hi_cnt[0]}, k * (L - C + 1 - R));
      chk("db_second", {16'h0000, hi_cnt[1]}, k * (C - F));
      chk("db_gap", {16'h0000, shoot_cnt}, 0);
    end
    wr(ga(0, GO_DBCTL), 0); wr(ga(0, GO_CMPA), L + 1);
    wr(ga(0, GO_INTEN), 32'h0000_0108);
    repeat (3 * (L + 1)) @(posedge REF_CLK);
    measure(k * (L + 1));
    chk("cmp_over_irq", n_irq, 0);
    chk("zero_trig", n_trg, k);
    chk("cmp_over_pin", {16'h0000, hi_cnt[0]}, k * (L + 1));
    wr(OFS_FAULT, 32'h0000_0001); wr(OFS_INVERT, 32'h0000_0002);
    wr(OFS_ENABLE, 32'h0000_0001);
    @(posedge REF_CLK); FAULT <= 1'b1;
    measure(20);
    chk("fault_pin0", {16'h0000, hi_cnt[0]}, 0);
    chk("inv_dis_pin1", {16'h0000, hi_cnt[1]}, 20);
    // Only gen0 runs, and in count-down, so every direction bit reads low
    rd(OFS_STATUS); chk("status_fault", rd_v, 32'h0000_0001);
    @(posedge REF_CLK); FAULT <= 1'b0;
    measure(20);
    chk("unfault_pin0", {16'h0000, hi_cnt[0]}, 20);
    wr(ga(0, GO_CTL), 0); wr(OFS_INVERT, 0);
    gs = 1;
    L = 3 + ($unsigned($random(seed)) % 16);
    C = 1 + ($unsigned($random(seed)) % (L - 1));
    // Gen2: both comparators equal, cross actions would spoil the wave
    wr(ga(2, GO_LOAD), L); wr(ga(2, GO_CMPA), C); wr(ga(2, GO_CMPB), C);
    wr(ga(2, GO_GENA), av(ACT_HIGH, EV_AUP) | av(ACT_LOW, EV_ADN) |
                       av(ACT_LOW, EV_BUP) | av(ACT_HIGH, EV_BDN));
    wr(ga(2, GO_GENB), av(ACT_HIGH, EV_AUP) | av(ACT_LOW, EV_ADN) |
                       av(ACT_INV, EV_BUP) | av(ACT_INV, EV_BDN));
    wr(ga(2, GO_CTL), 3);
    wr(ga(1, GO_LOAD), L); wr(ga(1, GO_CMPA), C);
    wr(ga(1, GO_GENA), (32'(ACT_HIGH) << (2 * EV_AUP)) | (32'(ACT_LOW) << (2 * EV_ADN)));
    wr(ga(1, GO_INTEN), 32'h0000_0001); wr(OFS_ENABLE, 32'h0000_003c);
    wr(ga(1, GO_CTL), 3);
    wait_irq(1); measure(k * 2 * L);
    chk("ud_zero", n_irq, k);
    chk("ud_pin2", {16'h0000, hi_cnt[2]}, k * 2 * (L - C));
    chk("ud_pin3", {16'h0000, hi_cnt[3]}, 0);
    chk("both_pin4", {16'h0000, hi_cnt[4]}, k * 2 * (L - C));
    chk("both_pin5", {16'h0000, hi_cnt[5]}, k * 2 * (L - C));
    // Counter restarts at zero on the sync write, then climbs one per edge
    wr(OFS_SYNC, 32'h0000_0002); rd(ga(1, GO_COUNT));
    chk("sync_count", rd_v, 32'h0000_0001);
    give_verdict();
  end
endmodule
